// File: verilog/prxdc_pkg.sv
`default_nettype none
package prxdc_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PS = 8000;                    // pclk period, 125 MHz
  localparam int WIN_US = 10;                      // 100M squelch window
  localparam int WIN_CYC = (WIN_US * 1000000) / CLK_PS;       // longest: floor
  localparam int SQ10_MIN_NS = 50;                 // 10M crossing span, least
  localparam int SQ10_MAX_NS = 250;                // 10M crossing span, most
  localparam int SQ10_MIN_CYC = (SQ10_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SQ10_MAX_CYC = (SQ10_MAX_NS * 1000) / CLK_PS;
  localparam int SOI_NS = 200;                     // missing transitions = idle
  localparam int SOI_CYC = (SOI_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [2:0] XING_100 = 3'h4;          // crossings to unsquelch
  localparam logic [2:0] XING_10 = 3'h3;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int C_EQ_DIS = 0;                     // equalizer held at zero length
  localparam int C_LVL_ADJ = 1;                    // thresholds lowered 4.5 dB
  localparam int C_COL_TEST = 2;                   // txen looped onto col
  localparam int C_FULL_DUP = 3;
  localparam int C_SPEED100 = 4;
  localparam int C_LOOPBACK = 5;
  localparam logic [5:0] CTRL_RST = 6'h10;         // 100M half duplex
  localparam int S_BAD_SSD = 0;                    // write one to clear
  localparam int S_BAD_ESD = 1;                    // write one to clear
  localparam int S_UNSQ = 2;
  localparam int S_RXST = 3;                       // two bits
  localparam int S_COL = 5;
  // ----------------------------------------------------------------
  // 5b code groups
  // ----------------------------------------------------------------
  localparam logic [4:0] SYM_I = 5'h1f;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0d;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [7:0] PRE_55 = 8'h55;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic {SQ_OFF = 1'b0, SQ_ON = 1'b1} prxdc_sq_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_RECV = 2'b01, RX_FCAR = 2'b10} prxdc_rx_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_J = 3'b001, TX_K = 3'b010, TX_DATA = 3'b011, TX_T = 3'b100, TX_R = 3'b101
  } prxdc_tx_t;
endpackage : prxdc_pkg
`default_nettype wire

// File: verilog/prxdc_top.sv
`default_nettype none
// Summary of operation
// - 100M: four alternating crossings in 10us unsquelch
// - unsquelch selects lower threshold level
// - 100M: 10us without crossings re-squelches
// - 10M: three crossings within 50-250ns unsquelch
// - 10M: idle re-squelches; no link effect
// - equalizer disable holds zero-length response
// - level adjust lowers both thresholds 4.5dB
// - half duplex tx while receiving raises col
// - no collision: full duplex, link fail, loopback
// - 10M collision zeros data; sqe, jabber collide
// - collision test loops txen, disables outputs
// - encoder sends j/k instead of preamble
// - idle groups give no valid data
// - j/k group starts reception, delivers 5/5
// - bad start group: false carrier, bad ssd
// - after false carrier wait for idle pair
// - other bad groups ignored, stay idle
// - encoder appends t/r after last data
// - t/r group ends reception cleanly
// - idle pair mid-packet: error, bad esd
// - 10M unsquelch asserts carrier sense
// - 10M missing transitions end reception
module prxdc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sq_pos,          // squelch comparator, positive (async)
  input wire logic sq_neg,          // squelch comparator, negative (async)
  input wire logic zc_trans,        // 10M zero-crossing transition seen (async)
  input wire logic code_stb,        // one 10-bit group ready
  input wire logic [9:0] code_grp,  // first symbol in [9:5]
  input wire logic [3:0] rx10_nib,  // 10M decoded nibble
  input wire logic sym_stb,         // transmit symbol strobe
  input wire logic mac_txen,
  input wire logic [3:0] mac_txd,
  input wire logic sqe_test,
  input wire logic jabber,
  input wire logic link_fail,
  output logic [4:0] tx_code,
  output logic tp_out_en,
  output logic thr_unsq,
  output logic thr_lower,
  output logic eq_zero_len,
  output logic mii_crs,
  output logic mii_rx_dv,
  output logic mii_rx_er,
  output logic [7:0] mii_rxd,
  output logic mii_col,
  output logic false_car
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] s1;                 // sync stage one: pos, neg, trans
    logic [2:0] s2;                 // sync stage two
    logic [1:0] s3;                 // delayed pos/neg for edge detect
    logic last_pol;                 // polarity of last crossing
    logic [2:0] xcnt;               // crossings counted in window
    logic [10:0] win;               // window / watchdog counter
    logic [4:0] idle_cnt;           // 10M cycles with no transition
    prxdc_pkg::prxdc_sq_t sq;
    prxdc_pkg::prxdc_rx_t rx;
    prxdc_pkg::prxdc_tx_t tx;
    logic [4:0] tx_code;
    logic [7:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic fcar;
    logic col;
    logic bad_ssd;
    logic bad_esd;
    logic [5:0] ctrl;               // software copy
    logic [5:0] cfg;                // copy in use, taken on symbol strobe
    logic [31:0] prdata;
  } prxdc_st_t;

  prxdc_st_t st_r;                  // registered state
  prxdc_st_t st_nxt;                // next state

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // two zeros with at least one bit between them
  function automatic logic prxdc_nc_zeros(input logic [9:0] g);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      for (int j = i + 2; j < 10; j++) begin
        if (!g[i] && !g[j]) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction : prxdc_nc_zeros

  // 4b to 5b data code
  function automatic logic [4:0] prxdc_enc(input logic [3:0] n);
    logic [4:0] c;
    unique case (n)
      4'h0: c = 5'h1e;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0a;
      4'h5: c = 5'h0b;
      4'h6: c = 5'h0e;
      4'h7: c = 5'h0f;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'ha: c = 5'h16;
      4'hb: c = 5'h17;
      4'hc: c = 5'h1a;
      4'hd: c = 5'h1b;
      4'he: c = 5'h1c;
      4'hf: c = 5'h1d;
    endcase
    return c;
  endfunction : prxdc_enc

  // 5b to 4b by reverse search; bit 4 flags an invalid code
  function automatic logic [4:0] prxdc_dec(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h10;
    for (int k = 0; k < 16; k++) begin
      if (prxdc_enc(4'(k)) == c) begin
        r = {1'b0, 4'(k)};
      end
    end
    return r;
  endfunction : prxdc_dec

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic xing;                       // rising edge of either comparator
  logic xpol;                       // its polarity, 1 = positive
  logic alt;                        // crossing with polarity change
  logic spd100;
  logic [4:0] dec_hi;
  logic [4:0] dec_lo;
  logic col_en;
  logic receiving;

  always_comb begin
    st_nxt = st_r;
    xing = (st_r.s2[2] && !st_r.s3[1]) || (st_r.s2[1] && !st_r.s3[0]);
    xpol = st_r.s2[2] && !st_r.s3[1];
    // first crossing of a squelched run needs no partner; after that polarity must flip
    alt = xing && (((st_r.sq == prxdc_pkg::SQ_OFF) && (st_r.xcnt == 3'h0)) || (xpol != st_r.last_pol));
    spd100 = st_r.cfg[prxdc_pkg::C_SPEED100];
    dec_hi = prxdc_dec(code_grp[9:5]);
    dec_lo = prxdc_dec(code_grp[4:0]);
    // synchronisers: stage one read only by stage two
    st_nxt.s1 = {sq_pos, sq_neg, zc_trans};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2[2:1];
    if (xing) begin
      st_nxt.last_pol = xpol;
    end
    if (sym_stb) begin
      st_nxt.cfg = st_r.ctrl;
    end
    // squelch machine
    unique case (st_r.sq)
      prxdc_pkg::SQ_OFF: begin
        st_nxt.idle_cnt = '0;
        if (st_r.xcnt != 3'h0) begin
          st_nxt.win = st_r.win + 11'h001;
        end
        if (spd100) begin
          if (alt && (st_r.xcnt + 3'h1 >= prxdc_pkg::XING_100)) begin
            st_nxt.sq = prxdc_pkg::SQ_ON;
            st_nxt.xcnt = '0;
            st_nxt.win = '0;
          end else if (alt) begin
            st_nxt.xcnt = st_r.xcnt + 3'h1;
            if (st_r.xcnt == 3'h0) begin
              st_nxt.win = '0;
            end
          end else if (st_r.win >= 11'(prxdc_pkg::WIN_CYC - 1)) begin
            st_nxt.xcnt = '0;       // window ran out, start over
            st_nxt.win = '0;
          end
        end else begin
          if (alt && (st_r.xcnt + 3'h1 >= prxdc_pkg::XING_10)
              && (st_r.win >= 11'(prxdc_pkg::SQ10_MIN_CYC))) begin
            st_nxt.sq = prxdc_pkg::SQ_ON;
            st_nxt.xcnt = '0;
            st_nxt.win = '0;
          end else if (alt && (st_r.xcnt + 3'h1 < prxdc_pkg::XING_10)) begin
            st_nxt.xcnt = st_r.xcnt + 3'h1;
            if (st_r.xcnt == 3'h0) begin
              st_nxt.win = '0;
            end
          end else if (alt || (st_r.win > 11'(prxdc_pkg::SQ10_MAX_CYC))) begin
            st_nxt.xcnt = '0;       // too fast or too slow: noise
            st_nxt.win = '0;
          end
        end
      end
      prxdc_pkg::SQ_ON: begin
        st_nxt.xcnt = '0;
        if (spd100) begin
          st_nxt.idle_cnt = '0;
          if (alt) begin
            st_nxt.win = '0;
          end else if (st_r.win >= 11'(prxdc_pkg::WIN_CYC - 1)) begin
            st_nxt.sq = prxdc_pkg::SQ_OFF;
            st_nxt.win = '0;
          end else begin
            st_nxt.win = st_r.win + 11'h001;
          end
        end else begin
          st_nxt.win = '0;
          // missing transitions mean start of idle
          if (st_r.s2[0]) begin
            st_nxt.idle_cnt = '0;
          end else if (st_r.idle_cnt >= 5'(prxdc_pkg::SOI_CYC - 1)) begin
            st_nxt.sq = prxdc_pkg::SQ_OFF;
            st_nxt.idle_cnt = '0;
          end else begin
            st_nxt.idle_cnt = st_r.idle_cnt + 5'h01;
          end
        end
      end
    endcase
    // 100M delimiter decode, one group per strobe
    if (spd100 && code_stb) begin
      unique case (st_r.rx)
        prxdc_pkg::RX_IDLE: begin
          st_nxt.rx_dv = 1'b0;
          st_nxt.rx_er = 1'b0;
          st_nxt.fcar = 1'b0;
          if (code_grp == {prxdc_pkg::SYM_J, prxdc_pkg::SYM_K}) begin
            st_nxt.rx = prxdc_pkg::RX_RECV;
            st_nxt.rx_dv = 1'b1;
            st_nxt.rxd = prxdc_pkg::PRE_55;
          end else if (code_grp != {prxdc_pkg::SYM_I, prxdc_pkg::SYM_I}
                       && prxdc_nc_zeros(code_grp)) begin
            st_nxt.rx = prxdc_pkg::RX_FCAR;
            st_nxt.rx_er = 1'b1;
            st_nxt.fcar = 1'b1;
            st_nxt.bad_ssd = 1'b1;
          end
        end
        prxdc_pkg::RX_RECV: begin
          if (code_grp == {prxdc_pkg::SYM_T, prxdc_pkg::SYM_R}) begin
            st_nxt.rx = prxdc_pkg::RX_IDLE;
            st_nxt.rx_dv = 1'b0;
            st_nxt.rx_er = 1'b0;
          end else if (code_grp == {prxdc_pkg::SYM_I, prxdc_pkg::SYM_I}) begin
            st_nxt.rx = prxdc_pkg::RX_IDLE;
            st_nxt.rx_dv = 1'b1;
            st_nxt.rx_er = 1'b1;
            st_nxt.bad_esd = 1'b1;
          end else begin
            st_nxt.rx_dv = 1'b1;
            st_nxt.rx_er = dec_hi[4] || dec_lo[4];
            st_nxt.rxd = {dec_lo[3:0], dec_hi[3:0]};   // first nibble low
          end
        end
        prxdc_pkg::RX_FCAR: begin
          if (code_grp == {prxdc_pkg::SYM_I, prxdc_pkg::SYM_I}) begin
            st_nxt.rx = prxdc_pkg::RX_IDLE;
            st_nxt.rx_er = 1'b0;
            st_nxt.fcar = 1'b0;
          end
        end
        default: begin
          st_nxt.rx = prxdc_pkg::RX_IDLE;
        end
      endcase
    end else if (!spd100) begin
      st_nxt.rx = prxdc_pkg::RX_IDLE;
      st_nxt.fcar = 1'b0;
      st_nxt.rx_er = 1'b0;
      st_nxt.rx_dv = (st_r.sq == prxdc_pkg::SQ_ON);
      st_nxt.rxd = st_r.col ? 8'h00 : {4'h0, rx10_nib};
    end
    // collision
    receiving = spd100 ? (st_r.rx != prxdc_pkg::RX_IDLE) : (st_r.sq == prxdc_pkg::SQ_ON);
    col_en = !st_r.cfg[prxdc_pkg::C_FULL_DUP] && !link_fail && !st_r.cfg[prxdc_pkg::C_LOOPBACK];
    if (st_r.cfg[prxdc_pkg::C_COL_TEST]) begin
      st_nxt.col = mac_txen;
    end else begin
      st_nxt.col = col_en && ((mac_txen && receiving) || (!spd100 && (sqe_test || jabber)));
    end
    // 4b5b transmit framing
    if (sym_stb) begin
      unique case (st_r.tx)
        prxdc_pkg::TX_IDLE: begin
          st_nxt.tx_code = prxdc_pkg::SYM_I;
          if (mac_txen) begin
            st_nxt.tx = prxdc_pkg::TX_J;
            st_nxt.tx_code = prxdc_pkg::SYM_J;
          end
        end
        prxdc_pkg::TX_J: begin
          st_nxt.tx = prxdc_pkg::TX_K;
          st_nxt.tx_code = prxdc_pkg::SYM_K;
        end
        prxdc_pkg::TX_K, prxdc_pkg::TX_DATA: begin
          if (mac_txen) begin
            st_nxt.tx = prxdc_pkg::TX_DATA;
            st_nxt.tx_code = prxdc_enc(mac_txd);
          end else begin
            // t then r after last data
            st_nxt.tx = prxdc_pkg::TX_T;
            st_nxt.tx_code = prxdc_pkg::SYM_T;
          end
        end
        prxdc_pkg::TX_T: begin
          st_nxt.tx = prxdc_pkg::TX_R;
          st_nxt.tx_code = prxdc_pkg::SYM_R;
        end
        prxdc_pkg::TX_R: begin
          st_nxt.tx = prxdc_pkg::TX_IDLE;
          st_nxt.tx_code = prxdc_pkg::SYM_I;
        end
        default: begin
          st_nxt.tx = prxdc_pkg::TX_IDLE;
        end
      endcase
    end
    // apb: read data latched in setup, writes in access
    if (psel && !penable) begin
      st_nxt.prdata = '0;
      if (paddr == prxdc_pkg::CTRL_OFS) begin
        st_nxt.prdata[5:0] = st_r.ctrl;
      end else if (paddr == prxdc_pkg::STAT_OFS) begin
        st_nxt.prdata[prxdc_pkg::S_BAD_SSD] = st_r.bad_ssd;
        st_nxt.prdata[prxdc_pkg::S_BAD_ESD] = st_r.bad_esd;
        st_nxt.prdata[prxdc_pkg::S_UNSQ] = (st_r.sq == prxdc_pkg::SQ_ON);
        st_nxt.prdata[prxdc_pkg::S_RXST +: 2] = st_r.rx;
        st_nxt.prdata[prxdc_pkg::S_COL] = st_r.col;
      end
    end
    if (psel && penable && pwrite) begin
      if (paddr == prxdc_pkg::CTRL_OFS) begin
        st_nxt.ctrl = pwdata[5:0];
      end else if (paddr == prxdc_pkg::STAT_OFS) begin
        // a new event in the same cycle beats the clear only if the flag was not already set
        if (pwdata[prxdc_pkg::S_BAD_SSD] && !(st_nxt.bad_ssd && !st_r.bad_ssd)) begin
          st_nxt.bad_ssd = 1'b0;
        end
        if (pwdata[prxdc_pkg::S_BAD_ESD] && !(st_nxt.bad_esd && !st_r.bad_esd)) begin
          st_nxt.bad_esd = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{sq: prxdc_pkg::SQ_OFF, rx: prxdc_pkg::RX_IDLE, tx: prxdc_pkg::TX_IDLE,
                tx_code: prxdc_pkg::SYM_I, ctrl: prxdc_pkg::CTRL_RST,
                cfg: prxdc_pkg::CTRL_RST, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st_r.prdata;
  assign pready = 1'b1;             // zero wait states
  assign pslverr = psel && penable && (paddr != prxdc_pkg::CTRL_OFS) && (paddr != prxdc_pkg::STAT_OFS);
  assign tx_code = st_r.tx_code;
  assign tp_out_en = !st_r.cfg[prxdc_pkg::C_COL_TEST];
  assign thr_unsq = (st_r.sq == prxdc_pkg::SQ_ON);
  assign thr_lower = st_r.cfg[prxdc_pkg::C_LVL_ADJ];
  assign eq_zero_len = st_r.cfg[prxdc_pkg::C_EQ_DIS];
  assign mii_crs = st_r.cfg[prxdc_pkg::C_SPEED100] ? (st_r.rx == prxdc_pkg::RX_RECV) : thr_unsq;
  assign mii_rx_dv = st_r.rx_dv;
  assign mii_rx_er = st_r.rx_er;
  assign mii_rxd = st_r.rxd;
  assign mii_col = st_r.col;
  assign false_car = st_r.fcar;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  unsq_watchdog_a: assert property (
    (st_r.sq == prxdc_pkg::SQ_ON) && st_r.cfg[prxdc_pkg::C_SPEED100] && !alt
    && (st_r.win >= 11'(prxdc_pkg::WIN_CYC - 1)) |=> (st_r.sq == prxdc_pkg::SQ_OFF))
    else $error("unsquelch watchdog did not squelch");
  jk_start_a: assert property (
    st_r.cfg[prxdc_pkg::C_SPEED100] && code_stb && (st_r.rx == prxdc_pkg::RX_IDLE)
    && (code_grp == {prxdc_pkg::SYM_J, prxdc_pkg::SYM_K}) |=> mii_rx_dv && (mii_rxd == prxdc_pkg::PRE_55))
    else $error("j/k did not start reception");
  fcar_ssd_a: assert property (
    $rose(false_car) |-> st_r.bad_ssd && mii_rx_er)
    else $error("false carrier without bad ssd");
  fcar_hold_a: assert property (
    (st_r.rx == prxdc_pkg::RX_FCAR) && code_stb && (code_grp != {prxdc_pkg::SYM_I, prxdc_pkg::SYM_I})
    && st_r.cfg[prxdc_pkg::C_SPEED100] |=> (st_r.rx == prxdc_pkg::RX_FCAR))
    else $error("left false carrier without idle");
  early_end_a: assert property (
    st_r.cfg[prxdc_pkg::C_SPEED100] && code_stb && (st_r.rx == prxdc_pkg::RX_RECV)
    && (code_grp == {prxdc_pkg::SYM_I, prxdc_pkg::SYM_I}) |=> mii_rx_er && st_r.bad_esd)
    else $error("premature end not flagged");
  col_gate_a: assert property (
    (st_r.cfg[prxdc_pkg::C_FULL_DUP] || st_r.cfg[prxdc_pkg::C_LOOPBACK] || link_fail)
    && !st_r.cfg[prxdc_pkg::C_COL_TEST] |=> !mii_col)
    else $error("collision in gated mode");
  col_test_a: assert property (
    st_r.cfg[prxdc_pkg::C_COL_TEST] |-> !tp_out_en ##1 (mii_col == $past(mac_txen)))
    else $error("collision test loop broken");
  jk_encode_a: assert property (
    sym_stb && (st_r.tx == prxdc_pkg::TX_IDLE) && mac_txen |=> (tx_code == prxdc_pkg::SYM_J))
    else $error("j not sent");
  k_follow_a: assert property (
    sym_stb && (st_r.tx == prxdc_pkg::TX_J) |=> (tx_code == prxdc_pkg::SYM_K))
    else $error("k not sent after j");
  tr_encode_a: assert property (
    sym_stb && (st_r.tx == prxdc_pkg::TX_DATA) && !mac_txen |=> (tx_code == prxdc_pkg::SYM_T))
    else $error("t not sent after data");
  col_zero_a: assert property (
    !st_r.cfg[prxdc_pkg::C_SPEED100] && mii_col |=> (mii_rxd == 8'h00))
    else $error("10M data not zeroed in collision");
endmodule : prxdc_top
`default_nettype wire

// File: sim/prxdc_line_model.sv
`default_nettype none
// far side: descrambler handing one 10-bit group per strobe
module prxdc_line_model (
  input wire logic pclk,
  output logic code_stb,
  output logic [9:0] code_grp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    code_stb = 1'b0;
    code_grp = 10'h000;
  end
  // group holds one cycle only; afterwards the bus shows its inverse
  task automatic send(input logic [9:0] g);
    code_stb <= 1'b1;
    code_grp <= g;
    @(posedge pclk);
    code_stb <= 1'b0;
    code_grp <= ~g;
    repeat (3) @(posedge pclk);
  endtask : send
endmodule : prxdc_line_model
`default_nettype wire

// File: sim/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, sq_pos, sq_neg, code_stb, sym_stb, mac_txen, er;
  logic zc_trans, sqe_test, jabber, link_fail;
  logic pready, pslverr, tp_out_en, thr_unsq, thr_lower, eq_zero_len, mii_crs, mii_rx_dv, mii_rx_er;
  logic mii_col, false_car;
  logic [7:0] paddr, mii_rxd;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] code_grp;
  logic [3:0] mac_txd, rx10_nib, a, b;
  logic [4:0] tx_code;
  int mismatches, check_count, seed, i;
  // 4b5b data code groups, indexed by nibble
  logic [4:0] enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  prxdc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sq_pos(sq_pos),
    .sq_neg(sq_neg), .zc_trans(zc_trans), .code_stb(code_stb), .code_grp(code_grp), .rx10_nib(rx10_nib),
    .sym_stb(sym_stb), .mac_txen(mac_txen), .mac_txd(mac_txd), .sqe_test(sqe_test), .jabber(jabber),
    .link_fail(link_fail), .tx_code(tx_code), .tp_out_en(tp_out_en), .thr_unsq(thr_unsq),
    .thr_lower(thr_lower),
    .eq_zero_len(eq_zero_len), .mii_crs(mii_crs), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er),
    .mii_rxd(mii_rxd), .mii_col(mii_col), .false_car(false_car));
  prxdc_line_model u_line (.pclk(pclk), .code_stb(code_stb), .code_grp(code_grp));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one apb transfer; only the watchdog bounds the wait on pready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic sym(input logic en, input logic [3:0] d);
    sym_stb <= 1'b1;
    mac_txen <= en;
    mac_txd <= d;
    @(posedge pclk);
    sym_stb <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : sym
  // config copy only moves on a symbol strobe
  task automatic cfg(input logic [31:0] v);
    apb(1'b1, prxdc_pkg::CTRL_OFS, v);
    sym(1'b0, 4'h0);
  endtask : cfg
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  // alternating comparator crossings, six cycles apart
  task automatic xings(input int k);
    for (int j = 0; j < k; j++) begin
      sq_pos <= ~j[0];
      sq_neg <= j[0];
      repeat (3) @(posedge pclk);
      {sq_pos, sq_neg} <= 2'h0;
      repeat (3) @(posedge pclk);
    end
  endtask : xings
  initial begin
    {psel, penable, pwrite, sq_pos, sq_neg, sym_stb, mac_txen, zc_trans, sqe_test, jabber, link_fail} = 11'h000;
    {paddr, pwdata, mac_txd, rx10_nib} = 48'h0;
    seed = 45;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("tx_code", 32'(tx_code), 32'(prxdc_pkg::SYM_I));
    apb(1'b0, prxdc_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h10);
    apb(1'b1, 8'h40, 32'hffffffff);
    chk("slverr", 32'(er), 32'h1);
    u_line.send({prxdc_pkg::SYM_J, prxdc_pkg::SYM_K});
    chk("jk", 32'({mii_crs, mii_rx_dv, mii_rx_er, mii_rxd}), 32'h655);
    // transmit under reception: j, k, data, t, r, idle; collides
    sym(1'b1, 4'h5);
    chk("tx_j", 32'(tx_code), 32'(prxdc_pkg::SYM_J));
    chk("col", 32'(mii_col), 32'h1);
    sym(1'b1, 4'h5);
    chk("tx_k", 32'(tx_code), 32'(prxdc_pkg::SYM_K));
    for (i = 0; i < 8; i++) begin
      {a, b} = 8'($random(seed));
      sym(1'b1, a);
      chk("tx_d", 32'(tx_code), 32'(enc[a]));
      u_line.send({enc[a], enc[b]});
      chk("rxd", 32'({mii_rx_dv, mii_rx_er, mii_rxd}), {22'h0, 2'h2, b, a});
    end
    sym(1'b0, 4'h0);
    chk("tx_t", 32'(tx_code), 32'(prxdc_pkg::SYM_T));
    sym(1'b0, 4'h0);
    chk("tx_r", 32'(tx_code), 32'(prxdc_pkg::SYM_R));
    sym(1'b0, 4'h0);
    chk("tx_i", 32'(tx_code), 32'(prxdc_pkg::SYM_I));
    u_line.send({prxdc_pkg::SYM_T, prxdc_pkg::SYM_R});
    chk("tr", 32'({mii_crs, mii_rx_dv, mii_rx_er}), 32'h0);
    u_line.send({prxdc_pkg::SYM_J, prxdc_pkg::SYM_K});
    u_line.send(10'h3ff);
    chk("early_end", 32'(mii_rx_er), 32'h1);
    apb(1'b0, prxdc_pkg::STAT_OFS, 32'h0);
    chk("bad_esd", rd & 32'h3, 32'h2);
    apb(1'b1, prxdc_pkg::STAT_OFS, 32'h3);
    u_line.send(10'h000);
    chk("fcar", 32'({false_car, mii_rx_er}), 32'h3);
    u_line.send({prxdc_pkg::SYM_J, prxdc_pkg::SYM_K});
    chk("ssd_held", 32'({mii_rx_dv, false_car}), 32'h1);
    u_line.send(10'h3ff);
    u_line.send(10'h3fc);
    chk("discard", 32'({mii_crs, mii_rx_dv, false_car}), 32'h0);
    apb(1'b0, prxdc_pkg::STAT_OFS, 32'h0);
    chk("bad_ssd", rd & 32'h3, 32'h1);
    // four alternating crossings, then silence past the window
    xings(4);
    repeat (6) @(posedge pclk);
    chk("unsq", 32'(thr_unsq), 32'h1);
    repeat (1300) @(posedge pclk);
    chk("resq", 32'(thr_unsq), 32'h0);
    cfg(32'h13);
    chk("eq_lvl", 32'({eq_zero_len, thr_lower}), 32'h3);
    cfg(32'h14);
    mac_txen <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("coltest", 32'({mii_col, tp_out_en}), 32'h2);
    mac_txen <= 1'b0;
    cfg(32'h18);
    u_line.send({prxdc_pkg::SYM_J, prxdc_pkg::SYM_K});
    sym(1'b1, 4'h0);
    chk("fdx_col", 32'(mii_col), 32'h0);
    // 10M: sqe and jabber collide and zero the data; link fail gates them
    cfg(32'h00);
    rx10_nib <= 4'($random(seed));
    sqe_test <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("sqe_col", 32'({mii_col, mii_rxd}), 32'h100);
    {sqe_test, jabber} <= 2'h1;
    repeat (3) @(posedge pclk);
    chk("jab_col", 32'(mii_col), 32'h1);
    link_fail <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("lf_col", 32'(mii_col), 32'h0);
    {link_fail, jabber} <= 2'h0;
    repeat (3) @(posedge pclk);
    chk("rx10", 32'({mii_col, mii_rxd}), {28'h0, rx10_nib});
    // 10M: three crossings unsquelch while transitions last, then idle drops it
    zc_trans <= 1'b1;
    xings(3);
    chk("unsq10", 32'({thr_unsq, mii_crs, mii_rx_dv}), 32'h7);
    zc_trans <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("soi", 32'({thr_unsq, mii_crs, mii_rx_dv}), 32'h0);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
